/* rtl/pbwc_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - In soft-off, a press released under four seconds powers the system on.
// - Working, a short press requests soft-off or suspend from software.
// - Working, a press over four seconds forces power off without software.
// - Sleeping, short press wakes; press over four seconds powers off.
// - Switch, RTC, modem and PME wake from S1, S3 and S5.
// - USB, sleep button and IR wake only from S1; keyboard and mouse wake from S1 and standby.
// - One modem ring resumes from standby or S1.
// - Standby entered by idle time-out, suspend switch or software request.
// - Standby keeps serving interrupts; keyboard or mouse ends it, monitor on.
// - Power management enable is configurable and defaults to enabled.
// - Suspend-to-RAM keeps memory and wake logic on standby power.
module pbwc_top #(
  parameter int unsigned DEB_CYC = pbwc_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned HOLD_CYC = pbwc_pkg::HOLD_CYCLES,
  parameter int unsigned RST_CYC = pbwc_pkg::RST_HOLD_CYCLES,
  parameter int unsigned IDLE_CYC = pbwc_pkg::IDLE_CYCLES
) (
  // standby clock and power-on reset
  input wire logic core_clk,
  input wire logic arst_n,
  // front panel
  input wire logic pwr_sw_n,
  input wire logic susp_sw_n,
  // supply
  input wire logic pwr_good,
  output logic supply_on,
  output logic sys_rst_n,
  output logic mem_stby_pwr,
  output logic monitor_pwr,
  // configuration
  input wire logic pm_disable,
  input wire logic modem_irq_mask,
  // software side, same clock
  input wire logic sw_standby_req,
  input wire logic sw_sleep_s1_req,
  input wire logic sw_sleep_s3_req,
  input wire logic sw_off_req,
  input wire logic activity,
  output logic soft_off_req,
  // wake sources, asynchronous
  input wire logic rtc_alarm,
  input wire logic pme_n,
  input wire logic modem_ring,
  input wire logic usb_wake,
  input wire logic kbd_act,
  input wire logic mouse_act,
  input wire logic sleep_btn,
  input wire logic ir_cmd,
  // state
  output pbwc_pkg::pbwc_state_t pwr_state
);
  localparam int NW = 10;
  pbwc_btn_if pwr_if ();
  pbwc_btn_if susp_if ();
  logic [NW-1:0] raw_in;
  logic [NW-1:0] s1, s2, s3;
  logic [NW-1:0] lvl;
  logic pg_q;
  logic rtc_w, pme_w, ring_w, usb_w, kbd_w, mouse_w, slp_w, ir_w, pg_w;
  logic susp_prev, next_susp_prev, susp_edge;
  pbwc_pkg::pbwc_state_t state, next_state;
  logic [31:0] rst_cnt, next_rst_cnt;
  logic [31:0] idle_cnt, next_idle_cnt;
  logic rst_q, next_rst_q;
  logic sor, next_sor;
  logic mon, next_mon;
  logic pm_en, next_pm_en;
  logic wake_all, wake_s1;

  //////////////////////////////////////////////////////////////////////
  // switch decoders
  pbwc_button #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_pwr (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sw_n(pwr_sw_n),
    .btn(pwr_if.drv)
  );
  pbwc_button #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_susp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sw_n(susp_sw_n),
    .btn(susp_if.drv)
  );

  //////////////////////////////////////////////////////////////////////
  // three-flop synchronisers, change taken when stages 2 and 3 agree
  assign raw_in = {pwr_good, ir_cmd, sleep_btn, mouse_act, kbd_act,
                   usb_wake, modem_ring, ~pme_n, rtc_alarm, 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          lvl[gi] <= 1'b0;
        end else begin
          s1[gi] <= raw_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            lvl[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate
  assign rtc_w = lvl[1];
  assign pme_w = lvl[2];
  assign ring_w = lvl[3] & ~modem_irq_mask;
  assign usb_w = lvl[4];
  assign kbd_w = lvl[5];
  assign mouse_w = lvl[6];
  assign slp_w = lvl[7];
  assign ir_w = lvl[8];
  assign pg_w = lvl[9];
  assign pg_q = pg_w;

  //////////////////////////////////////////////////////////////////////
  // wake qualification
  assign wake_all = pwr_if.short_rel | rtc_w | pme_w | ring_w;
  assign wake_s1 = wake_all | usb_w | kbd_w | mouse_w | slp_w | ir_w;
  assign susp_edge = susp_if.pressed & ~susp_prev;

  //////////////////////////////////////////////////////////////////////
  // power state machine
  always_comb begin
    next_state = state;
    next_sor = 1'b0;
    next_susp_prev = susp_if.pressed;
    next_pm_en = ~pm_disable;
    next_mon = mon;
    next_idle_cnt = idle_cnt;
    case (state)
      pbwc_pkg::PBWC_S5: begin
        next_mon = 1'b0;
        if (wake_all) begin
          next_state = pbwc_pkg::PBWC_S0;
          next_mon = 1'b1;
        end
      end
      pbwc_pkg::PBWC_S0: begin
        next_mon = 1'b1;
        next_idle_cnt = activity ? 32'h0 : idle_cnt + 32'h1;
        if (pwr_if.long_hit) begin
          next_state = pbwc_pkg::PBWC_S5;
        end else if (pwr_if.short_rel) begin
          next_sor = 1'b1;
        end else if (sw_off_req) begin
          next_state = pbwc_pkg::PBWC_S5;
        end else if (sw_sleep_s3_req) begin
          next_state = pbwc_pkg::PBWC_S3;
        end else if (sw_sleep_s1_req) begin
          next_state = pbwc_pkg::PBWC_S1;
        end else if (pm_en && (susp_edge || sw_standby_req ||
                     idle_cnt >= IDLE_CYC - 1)) begin
          next_state = pbwc_pkg::PBWC_STBY;
          next_mon = 1'b0;
        end
        if (next_state != pbwc_pkg::PBWC_S0) begin
          next_idle_cnt = 32'h0;
        end
      end
      pbwc_pkg::PBWC_STBY: begin
        // supply and reset stay up so interrupts are still served
        if (pwr_if.long_hit) begin
          next_state = pbwc_pkg::PBWC_S5;
        end else if (kbd_w || mouse_w || activity || ring_w || susp_edge ||
                     pwr_if.short_rel) begin
          next_state = pbwc_pkg::PBWC_S0;
          next_mon = 1'b1;
        end
      end
      pbwc_pkg::PBWC_S1: begin
        if (pwr_if.long_hit) begin
          next_state = pbwc_pkg::PBWC_S5;
        end else if (wake_s1) begin
          next_state = pbwc_pkg::PBWC_S0;
          next_mon = 1'b1;
        end
      end
      pbwc_pkg::PBWC_S3: begin
        if (pwr_if.long_hit) begin
          next_state = pbwc_pkg::PBWC_S5;
        end else if (wake_all) begin
          next_state = pbwc_pkg::PBWC_S0;
          next_mon = 1'b1;
        end
      end
      default: begin
        next_state = pbwc_pkg::PBWC_S5;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // reset sequencing after power-good
  always_comb begin
    next_rst_cnt = 32'h0;
    next_rst_q = 1'b0;
    if (supply_on && pg_q) begin
      next_rst_cnt = rst_cnt;
      if (rst_cnt < RST_CYC) begin
        next_rst_cnt = rst_cnt + 32'h1;
      end
      next_rst_q = (rst_cnt >= RST_CYC);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pbwc_pkg::PBWC_S5;
      sor <= 1'b0;
      susp_prev <= 1'b0;
      pm_en <= pbwc_pkg::PM_ENABLE_RESET;
      mon <= 1'b0;
      idle_cnt <= 32'h0;
      rst_cnt <= 32'h0;
      rst_q <= 1'b0;
    end else begin
      state <= next_state;
      sor <= next_sor;
      susp_prev <= next_susp_prev;
      pm_en <= next_pm_en;
      mon <= next_mon;
      idle_cnt <= next_idle_cnt;
      rst_cnt <= next_rst_cnt;
      rst_q <= next_rst_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign supply_on = (state == pbwc_pkg::PBWC_S0) || (state == pbwc_pkg::PBWC_STBY) ||
                     (state == pbwc_pkg::PBWC_S1);
  assign sys_rst_n = rst_q;
  assign mem_stby_pwr = supply_on || (state == pbwc_pkg::PBWC_S3);
  assign monitor_pwr = mon;
  assign soft_off_req = sor;
  assign pwr_state = state;
endmodule
`default_nettype wire

/* include/pbwc_pkg.sv */
`default_nettype none
package pbwc_pkg;
  // timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned HOLD_MS = 4000;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_HOLD_MS = 100;
  localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_US = 10000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned IDLE_MS = 60000;
  localparam int unsigned IDLE_CYCLES = IDLE_MS * (CLK_HZ / 1000);
  // reset values
  localparam logic PM_ENABLE_RESET = 1'b1;
  // power states
  typedef enum logic [2:0] {
    PBWC_S5,
    PBWC_S0,
    PBWC_STBY,
    PBWC_S1,
    PBWC_S3
  } pbwc_state_t;
endpackage
`default_nettype wire

/* include/pbwc_btn_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pbwc_btn_if;
  logic pressed;
  logic short_rel;
  logic long_hit;
  modport drv (output pressed, output short_rel, output long_hit);
  modport use_ (input pressed, input short_rel, input long_hit);
endinterface
`default_nettype wire

/* rtl/pbwc_button.sv */
`timescale 1ns/100ps
`default_nettype none
module pbwc_button #(
  parameter int unsigned DEB_CYC = pbwc_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned HOLD_CYC = pbwc_pkg::HOLD_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // raw switch, active low
  input wire logic sw_n,
  // decoded presses
  pbwc_btn_if.drv btn
);
  logic [2:0] sync;
  logic stable, next_stable;
  logic [31:0] deb_cnt, next_deb_cnt;
  logic [31:0] hold_cnt, next_hold_cnt;
  logic short_rel, next_short_rel;
  logic long_hit, next_long_hit;

  always_comb begin
    next_stable = stable;
    next_deb_cnt = 32'h0;
    if ((sync[2] == sync[1]) && (sync[1] != stable)) begin
      next_deb_cnt = deb_cnt + 32'h1;
      if (deb_cnt >= DEB_CYC - 1) begin
        next_stable = sync[1];
        next_deb_cnt = 32'h0;
      end
    end
    next_short_rel = 1'b0;
    next_long_hit = 1'b0;
    next_hold_cnt = 32'h0;
    if (stable) begin
      next_hold_cnt = hold_cnt;
      if (hold_cnt < HOLD_CYC) begin
        next_hold_cnt = hold_cnt + 32'h1;
      end
      next_long_hit = (hold_cnt == HOLD_CYC - 1);
    end else if (hold_cnt != 32'h0 && hold_cnt < HOLD_CYC) begin
      next_short_rel = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync <= 3'h0;
      stable <= 1'b0;
      deb_cnt <= 32'h0;
      hold_cnt <= 32'h0;
      short_rel <= 1'b0;
      long_hit <= 1'b0;
    end else begin
      sync <= {sync[1:0], ~sw_n};
      stable <= next_stable;
      deb_cnt <= next_deb_cnt;
      hold_cnt <= next_hold_cnt;
      short_rel <= next_short_rel;
      long_hit <= next_long_hit;
    end
  end

  assign btn.pressed = stable;
  assign btn.short_rel = short_rel;
  assign btn.long_hit = long_hit;
endmodule
`default_nettype wire

/* verif/pbwc_supply_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pbwc_supply_model #(
  parameter int unsigned PG_DLY = 10
) (
  // clock
  input wire logic core_clk,
  // supply control
  input wire logic supply_on,
  input wire logic fail,
  output logic pwr_good
);
  int unsigned cnt = 0;
  always @(posedge core_clk) begin
    cnt <= (supply_on && !fail) ? ((cnt < PG_DLY) ? cnt + 1 : cnt) : 0;
  end
  // good drops at once, well ahead of the rails
  assign pwr_good = (cnt == PG_DLY) && supply_on && !fail;
endmodule
`default_nettype wire

/* verif/pbwc_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module pbwc_top_chk #(
  parameter int unsigned RST_CYC = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic pwr_good,
  input wire logic supply_on,
  input wire logic sys_rst_n,
  input wire logic mem_stby_pwr,
  input wire logic pm_disable,
  input wire logic kbd_act,
  input wire logic soft_off_req,
  input wire pbwc_pkg::pbwc_state_t pwr_state
);
  int unsigned pg_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_cnt <= 0;
    end else begin
      pg_cnt <= pwr_good ? ((pg_cnt < RST_CYC) ? pg_cnt + 1 : pg_cnt) : 0;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  property p_rst_hold;
    $rose(sys_rst_n) |-> pg_cnt >= RST_CYC;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset early");
  property p_pg_drop;
    $fell(pwr_good) |-> ##[1:5] !sys_rst_n;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("reset kept");
  property p_s5_off;
    pwr_state == pbwc_pkg::PBWC_S5 |-> !supply_on ##1 !sys_rst_n;
  endproperty
  a_s5_off: assert property (p_s5_off) else $error("supply on in off");
  property p_s3_mem;
    pwr_state == pbwc_pkg::PBWC_S3 |-> mem_stby_pwr;
  endproperty
  a_s3_mem: assert property (p_s3_mem) else $error("memory unpowered");
  property p_soft_pulse;
    soft_off_req |-> pwr_state == pbwc_pkg::PBWC_S0 ##1 !soft_off_req;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("bad soft off");
  property p_stby_up;
    pwr_state == pbwc_pkg::PBWC_STBY |-> supply_on && sys_rst_n;
  endproperty
  a_stby_up: assert property (p_stby_up) else $error("standby down");
  property p_pm_dis;
    pm_disable && $past(pm_disable) && pwr_state == pbwc_pkg::PBWC_S0
      |=> pwr_state != pbwc_pkg::PBWC_STBY;
  endproperty
  a_pm_dis: assert property (p_pm_dis) else $error("standby when off");
  property p_s1_wake;
    pwr_state == pbwc_pkg::PBWC_S1 && $rose(kbd_act) |-> ##[1:6] pwr_state == pbwc_pkg::PBWC_S0;
  endproperty
  a_s1_wake: assert property (p_s1_wake) else $error("no key wake");
endmodule
bind pbwc_top pbwc_top_chk #(.RST_CYC(RST_CYC)) u_chk (.core_clk, .arst_n, .pwr_good,
  .supply_on, .sys_rst_n, .mem_stby_pwr, .pm_disable, .kbd_act, .soft_off_req, .pwr_state);
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  logic core_clk = 1'b0, arst_n = 1'b0, pwr_sw_n = 1'b1, susp_sw_n = 1'b1, fail = 1'b0;
  logic pm_disable = 1'b1, modem_irq_mask = 1'b0, activity = 1'b0;
  logic sw_standby_req = 1'b0, sw_sleep_s1_req = 1'b0, sw_sleep_s3_req = 1'b0, sw_off_req = 1'b0;
  logic [7:0] src = 8'h00;
  wire logic rtc_alarm = src[0], pme_n = ~src[1], modem_ring = src[2], usb_wake = src[3];
  wire logic kbd_act = src[4], mouse_act = src[5], sleep_btn = src[6], ir_cmd = src[7];
  wire logic pwr_good, supply_on, sys_rst_n, mem_stby_pwr, monitor_pwr, soft_off_req;
  wire pbwc_pkg::pbwc_state_t pwr_state;
  int n_mismatch = 0, n_tests = 0;
  always #25 core_clk = ~core_clk;
  pbwc_top #(.DEB_CYC(4), .HOLD_CYC(100), .RST_CYC(20), .IDLE_CYC(200)) uut (
    .core_clk, .arst_n, .pwr_sw_n, .susp_sw_n, .pwr_good, .supply_on, .sys_rst_n,
    .mem_stby_pwr, .monitor_pwr, .pm_disable, .modem_irq_mask, .sw_standby_req,
    .sw_sleep_s1_req, .sw_sleep_s3_req, .sw_off_req, .activity, .soft_off_req, .rtc_alarm,
    .pme_n, .modem_ring, .usb_wake, .kbd_act, .mouse_act, .sleep_btn, .ir_cmd, .pwr_state);
  pbwc_supply_model #(.PG_DLY(10)) u_sup (.core_clk, .supply_on, .fail, .pwr_good);
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_st(input pbwc_pkg::pbwc_state_t s, input int lim);
    for (int i = 0; i < lim && pwr_state !== s; i++) step(1);
    `CK(pwr_state, s)
  endtask
  task automatic press(input int n);
    pwr_sw_n = 1'b0;
    step(n);
    pwr_sw_n = 1'b1;
    step(12);
  endtask
  // 0 light sleep, 1 suspend to ram, 2 off, 3 standby
  task automatic req(input int k);
    {sw_standby_req, sw_off_req, sw_sleep_s3_req, sw_sleep_s1_req} = 4'(1 << k);
    step(1);
    {sw_standby_req, sw_off_req, sw_sleep_s3_req, sw_sleep_s1_req} = 4'h0;
    step(2);
  endtask
  task automatic t_boot();
    press(30);
    wait_st(pbwc_pkg::PBWC_S0, 8);
    step(25);
    `CK(sys_rst_n, 1'b0)
    step(20);
    `CK(sys_rst_n, 1'b1)
  endtask
  task automatic t_short();
    int seen = 0;
    pwr_sw_n = 1'b0;
    step(30);
    pwr_sw_n = 1'b1;
    repeat (15) begin
      step(1);
      seen += (soft_off_req === 1'b1);
    end
    `CK(seen, 1)
    `CK(pwr_state, pbwc_pkg::PBWC_S0)
    fail = 1'b1;
    step(6);
    `CK(sys_rst_n, 1'b0)
    fail = 1'b0;
    step(45);
    `CK(sys_rst_n, 1'b1)
  endtask
  task automatic t_wake();
    pbwc_pkg::pbwc_state_t sl [3];
    sl = '{pbwc_pkg::PBWC_S1, pbwc_pkg::PBWC_S3, pbwc_pkg::PBWC_S5};
    for (int k = 0; k < 3; k++) begin
      for (int b = 0; b < 8; b++) begin
        req(k);
        `CK(pwr_state, sl[k])
        `CK(supply_on, k == 0)
        `CK(mem_stby_pwr, k != 2)
        src = 8'(1 << b);
        step(10);
        src = 8'h00;
        // let the synchronised level clear before the next sleep request
        step(6);
        `CK(pwr_state, (k == 0 || b < 3) ? pbwc_pkg::PBWC_S0 : sl[k])
        if (pwr_state !== pbwc_pkg::PBWC_S0) press(30);
        wait_st(pbwc_pkg::PBWC_S0, 8);
      end
    end
  endtask
  task automatic t_stby();
    pm_disable = 1'b0;
    modem_irq_mask = 1'b1;
    // enable settles and system reset is released before software asks
    step(40);
    req(3);
    wait_st(pbwc_pkg::PBWC_STBY, 4);
    src = 8'h04;
    step(10);
    `CK(pwr_state, pbwc_pkg::PBWC_STBY)
    src = 8'h00;
    step(6);
    `CK(pwr_state, pbwc_pkg::PBWC_STBY)
    modem_irq_mask = 1'b0;
    step(1);
    src = 8'h04;
    step(10);
    src = 8'h00;
    `CK(pwr_state, pbwc_pkg::PBWC_S0)
    susp_sw_n = 1'b0;
    step(30);
    susp_sw_n = 1'b1;
    wait_st(pbwc_pkg::PBWC_STBY, 8);
    src = 8'h20;
    wait_st(pbwc_pkg::PBWC_S0, 8);
    src = 8'h00;
    step(2);
    `CK(monitor_pwr, 1'b1)
    wait_st(pbwc_pkg::PBWC_STBY, 210);
    activity = 1'b1;
    step(2);
    activity = 1'b0;
    wait_st(pbwc_pkg::PBWC_S0, 4);
    pm_disable = 1'b1;
    step(2);
    req(3);
    step(5);
    `CK(pwr_state, pbwc_pkg::PBWC_S0)
  endtask
  task automatic t_long();
    press(130);
    `CK(pwr_state, pbwc_pkg::PBWC_S5)
    press(30);
    wait_st(pbwc_pkg::PBWC_S0, 8);
    req(0);
    press(130);
    `CK(pwr_state, pbwc_pkg::PBWC_S5)
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    step(16);
    arst_n = 1'b1;
    step(2);
    t_boot();
    t_short();
    t_wake();
    t_stby();
    t_long();
    report_and_stop();
  end
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
